// >>> pkg/wtpc_pkg.sv
// Purpose: Shared constants for the write-through page cache
// Assumes: 25 MHz reference clock
// Notes:   Entry layout, register codes and timing counts
package wtpc_pkg;
  // Geometry
  localparam int ENTRIES      = 1024;
  localparam int IDX_W        = 10;
  localparam int DATA_W       = 16;
  localparam int TAG_W        = 14;
  localparam int TAG_NORM_W   = 9;
  localparam int ENTRY_W      = 31;
  localparam int VALID_POS    = 16;
  localparam int TAG_LSB      = 17;
  // Internal register transfer codes
  localparam logic [3:0] CODE_CLEAR  = 4'ha;
  localparam logic [3:0] CODE_LOWER  = 4'hb;
  localparam logic [3:0] CODE_UPPER  = 4'hc;
  localparam logic [3:0] CODE_STATUS = 4'ha;
  // Status bit positions
  localparam int ST_FILLS     = 0;
  localparam int ST_ON        = 1;
  localparam int ST_SWDIS     = 2;
  // Reset values of the bypass limits: whole range inhibited
  localparam logic [13:0] LOWER_RST = 14'h0000;
  localparam logic [13:0] UPPER_RST = 14'h3fff;
  // Timing
  localparam int CLK_MHZ      = 25;
  localparam int CLEAR_US     = 60;
  localparam int CLEAR_CYC    = CLEAR_US * CLK_MHZ;
  localparam int LOOKUP_NS    = 50;
  localparam int LOOKUP_CYC   = (LOOKUP_NS * CLK_MHZ) / 1000;
endpackage

// >>> hw/wtpc_ram.sv
// Purpose: Entry storage with registered read data
// Assumes: One read or write port per cycle
// Notes:   A read at the address being written returns the old word
`timescale 1ns/1ps
module wtpc_ram #(
  parameter int DEPTH = 1024,
  parameter int AW    = 10,
  parameter int DW    = 31
) (
  // Clock
  input  wire logic          clk_i,
  // Access
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  output      logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [DEPTH];

  // Synchronous write, registered read
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    rdata_o <= mem[addr_i];
  end
endmodule

// >>> hw/wtpc_valid.sv
// Purpose: Valid flags with a walking clear
// Assumes: Reset clears every flag at once; a walking clear is driven through the clear port
// Notes:   Flags live in flops; a lookup sees them one cycle later, like the RAM read
`timescale 1ns/1ps
module wtpc_valid #(
  parameter int DEPTH = 1024,
  parameter int AW    = 10
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  // Set port
  input  wire logic          set_i,
  input  wire logic [AW-1:0] set_idx_i,
  // Clear port, one entry per cycle
  input  wire logic          clr_i,
  input  wire logic [AW-1:0] clr_idx_i,
  // Lookup
  input  wire logic [AW-1:0] rd_idx_i,
  output      logic          rd_valid_o
);
  logic [DEPTH-1:0] flag;

  // Clear then set, so a set at the same entry wins
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag <= '0;
    end else begin
      if (clr_i) begin
        flag[clr_idx_i] <= 1'b0;
      end
      if (set_i) begin
        flag[set_idx_i] <= 1'b1;
      end
    end
  end

  // Registered so it lines up with the RAM read
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= flag[rd_idx_i];
    end
  end
endmodule

// >>> hw/wtpc_top.sv
// Purpose: Direct-mapped write-through word cache on the translated page
// Assumes: One outstanding processor reference; memory answers mem_rdy_i
// Notes:   Lookup takes one cycle after req_i, well within the lookup time
//
// Contract
// - Every write goes to memory and cache; code skips the cache when disabled or inside the limits
// - Storage is 1K entries of 31 bits
// - Tag 14 bits extended, 9 normal
// - Index is address bits zero to nine
// - Data low, valid bit 16, tag above
// - Write loads tag, data, sets valid
// - Read hit returns word, suppresses memory
// - Read miss runs memory, then fills entry
// - Lookup finishes within translation time
// - Clear code resets flags, disables 60us
// - Pages within limits are never cached
// - Codes eleven, twelve load lower, upper
// - Master clear inhibits whole range
// - All word kinds cached identically
// - Status bit 0: next reference fills
// - Status bit 1: present and operating
// - Status bit 2: manual switch disable
// - Absent option reads one in bit 2
`timescale 1ns/1ps
module wtpc_top #(
  parameter int          CLEAR_CYCLES = wtpc_pkg::CLEAR_CYC,
  parameter bit          PRESENT      = 1'b1
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // Master clear and mode
  input  wire logic        master_clear_i,
  input  wire logic        extended_mode_i,
  input  wire logic        switch_disable_flag_i,
  // Processor reference
  input  wire logic        req_i,
  input  wire logic        write_i,
  input  wire logic [9:0]  page_word_offset_i,
  input  wire logic [13:0] translated_page_number_i,
  input  wire logic [15:0] wdata_i,
  output      logic        hit_o,
  output      logic [15:0] cpu_internal_bus_o,
  output      logic        busy_o,
  // Memory cycle
  output      logic        mem_req_o,
  output      logic        mem_write_o,
  output      logic [23:0] mem_addr_o,
  output      logic [15:0] mem_wdata_o,
  input  wire logic        mem_rdy_i,
  input  wire logic [15:0] mem_rdata_i,
  // Internal register transfer
  input  wire logic        write_internal_reg_instr_i,
  input  wire logic        read_internal_reg_instr_i,
  input  wire logic [3:0]  reg_code_i,
  input  wire logic [15:0] accumulator_i,
  output      logic [15:0] cache_status_word_o
);
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_LOOK = 2'b01,
    S_MEM  = 2'b10
  } wtpc_state_t;

  // Reset synchroniser
  logic rst_s1;
  logic rst_n;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // Significant tag bits depend on addressing mode
  function automatic logic [13:0] tag_of(input logic [13:0] p, input logic ext);
    tag_of = ext ? p : {5'h00, p[8:0]};
  endfunction

  function automatic logic bypassed(input logic [13:0] p, input logic [13:0] lo,
                                    input logic [13:0] hi);
    bypassed = (p >= lo) && (p <= hi);
  endfunction

  wtpc_state_t     state;
  logic [13:0]     lower_bypass_page_limit;
  logic [13:0]     upper_bypass_page_limit;
  logic [10:0]     clr_cnt;
  logic            clearing;
  logic [31:0]     dis_cnt;
  logic            next_ref_fills_flag;
  logic            arm_fills;
  logic            ref_wr;
  logic [9:0]      ref_idx;
  logic [13:0]     ref_page;
  logic [15:0]     ref_data;
  logic [30:0]     rd_entry;
  logic            rd_valid;
  logic            ram_we;
  logic [9:0]      ram_addr;
  logic [30:0]     ram_wdata;
  logic            enabled;
  logic            lookup_hit;
  logic            may_fill;
  logic            fill_now;
  logic            clear_cmd;

  assign clear_cmd = write_internal_reg_instr_i && reg_code_i == wtpc_pkg::CODE_CLEAR;
  // Off while the walk runs too, so a short window cannot expose stale flags
  assign enabled   = PRESENT && !switch_disable_flag_i && !clearing &&
                     dis_cnt == 32'h0000_0000;
  assign may_fill  = enabled &&
                     !bypassed(ref_page, lower_bypass_page_limit,
                               upper_bypass_page_limit);
  // Hit needs equal tag and valid flag; mode masks upper tag bits
  assign lookup_hit = enabled && rd_valid &&
                      rd_entry[wtpc_pkg::TAG_LSB +: wtpc_pkg::TAG_W] ==
                      tag_of(ref_page, extended_mode_i);
  assign fill_now  = (state == S_LOOK && ref_wr && may_fill) ||
                     (state == S_MEM && !ref_wr && mem_rdy_i && may_fill);

  // Storage port: write fills, otherwise read at the new index
  assign ram_we    = fill_now;
  assign ram_addr  = (state == S_IDLE) ? page_word_offset_i : ref_idx;
  assign ram_wdata = {tag_of(ref_page, extended_mode_i), 1'b1,
                      ref_wr ? ref_data : mem_rdata_i};

  wtpc_ram #(
    .DEPTH (wtpc_pkg::ENTRIES),
    .AW    (wtpc_pkg::IDX_W),
    .DW    (wtpc_pkg::ENTRY_W)
  ) u_ram (
    .clk_i   (ref_clk_i),
    .we_i    (ram_we),
    .addr_i  (ram_addr),
    .wdata_i (ram_wdata),
    .rdata_o (rd_entry)
  );

  wtpc_valid #(
    .DEPTH (wtpc_pkg::ENTRIES),
    .AW    (wtpc_pkg::IDX_W)
  ) u_valid (
    .clk_i      (ref_clk_i),
    .rst_n_i    (rst_n),
    .set_i      (fill_now),
    .set_idx_i  (ref_idx),
    .clr_i      (clearing),
    .clr_idx_i  (clr_cnt[9:0]),
    .rd_idx_i   (ram_addr),
    .rd_valid_o (rd_valid)
  );

  // Capture the reference; instructions and operands take the same path
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ref_wr   <= 1'b0;
      ref_idx  <= 10'h000;
      ref_page <= 14'h0000;
      ref_data <= 16'h0000;
    end else if (state == S_IDLE && req_i) begin
      ref_wr   <= write_i;
      ref_idx  <= page_word_offset_i;
      ref_page <= translated_page_number_i;
      ref_data <= wdata_i;
    end
  end

  // Reference sequencer: one lookup cycle, then memory unless read hit
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
    end else begin
      case (state)
        S_IDLE: begin
          if (req_i) begin
            state <= S_LOOK;
          end
        end
        S_LOOK: begin
          if (!ref_wr && lookup_hit) begin
            state <= S_IDLE;
          end else begin
            state <= S_MEM;
          end
        end
        S_MEM: begin
          if (mem_rdy_i) begin
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Memory request: writes always, reads only on miss
  assign mem_req_o   = state == S_MEM;
  assign mem_write_o = ref_wr;
  assign mem_addr_o  = {ref_page, ref_idx};
  assign mem_wdata_o = ref_data;
  assign busy_o      = state != S_IDLE;

  // Read data to processor from cache or memory
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hit_o              <= 1'b0;
      cpu_internal_bus_o <= 16'h0000;
    end else begin
      hit_o <= state == S_LOOK && !ref_wr && lookup_hit;
      if (state == S_LOOK && !ref_wr && lookup_hit) begin
        cpu_internal_bus_o <= rd_entry[15:0];
      end else if (state == S_MEM && !ref_wr && mem_rdy_i) begin
        cpu_internal_bus_o <= mem_rdata_i;
      end
    end
  end

  // Limit registers; master clear opens the whole inhibited range
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      lower_bypass_page_limit <= wtpc_pkg::LOWER_RST;
      upper_bypass_page_limit <= wtpc_pkg::UPPER_RST;
    end else if (master_clear_i) begin
      lower_bypass_page_limit <= wtpc_pkg::LOWER_RST;
      upper_bypass_page_limit <= wtpc_pkg::UPPER_RST;
    end else if (write_internal_reg_instr_i) begin
      if (reg_code_i == wtpc_pkg::CODE_LOWER) begin
        lower_bypass_page_limit <= accumulator_i[13:0];
      end
      if (reg_code_i == wtpc_pkg::CODE_UPPER) begin
        upper_bypass_page_limit <= accumulator_i[13:0];
      end
    end
  end

  // Walking flag clear, one entry per cycle
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      clearing <= 1'b1;
      clr_cnt  <= 11'h000;
    end else if (clear_cmd || master_clear_i) begin
      clearing <= 1'b1;
      clr_cnt  <= 11'h000;
    end else if (clearing) begin
      clr_cnt <= clr_cnt + 11'h001;
      if (clr_cnt[9:0] == 10'h3ff) begin
        clearing <= 1'b0;
      end
    end
  end

  // Disable window after clear; the walk keeps the cache off as well
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dis_cnt <= 32'(CLEAR_CYCLES);
    end else if (clear_cmd || master_clear_i) begin
      dis_cnt <= 32'(CLEAR_CYCLES);
    end else if (dis_cnt != 32'h0000_0000) begin
      dis_cnt <= dis_cnt - 32'h0000_0001;
    end
  end

  // Fill prediction armed by a status read for the prefetched fetch
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      arm_fills           <= 1'b0;
      next_ref_fills_flag <= 1'b0;
    end else begin
      if (read_internal_reg_instr_i && reg_code_i == wtpc_pkg::CODE_STATUS) begin
        arm_fills <= 1'b1;
      end else if (state == S_LOOK) begin
        arm_fills <= 1'b0;
        // Only the reference right after a status read is recorded
        if (arm_fills) begin
          next_ref_fills_flag <= ref_wr ? may_fill : (!lookup_hit && may_fill);
        end
      end
    end
  end

  // Status word; absent option reads one in bit 2
  always_comb begin
    cache_status_word_o = 16'h0000;
    if (!PRESENT) begin
      cache_status_word_o[wtpc_pkg::ST_SWDIS] = 1'b1;
    end else begin
      cache_status_word_o[wtpc_pkg::ST_FILLS] = next_ref_fills_flag;
      cache_status_word_o[wtpc_pkg::ST_ON]    = enabled;
      cache_status_word_o[wtpc_pkg::ST_SWDIS] = switch_disable_flag_i;
    end
  end

  // Checks
  a_hit_no_mem: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (state == S_LOOK && !ref_wr && lookup_hit) |=> !mem_req_o && hit_o)
    else $error("read hit still started memory");
  a_write_to_mem: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (state == S_LOOK && ref_wr) |=> mem_req_o && mem_write_o)
    else $error("write not forwarded to memory");
  a_bypass_no_fill: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    ram_we |-> !bypassed(ref_page, lower_bypass_page_limit, upper_bypass_page_limit))
    else $error("fill inside bypass window");
  a_disabled_miss: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    switch_disable_flag_i |-> !lookup_hit && !ram_we)
    else $error("disabled cache hit or filled");
  a_clear_off: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    clear_cmd |=> !cache_status_word_o[wtpc_pkg::ST_ON] [*8])
    else $error("cache on too soon after clear");
  a_mc_limits: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    master_clear_i |=> lower_bypass_page_limit == wtpc_pkg::LOWER_RST &&
                       upper_bypass_page_limit == wtpc_pkg::UPPER_RST)
    else $error("limits not opened by master clear");
  a_lower_load: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (write_internal_reg_instr_i && reg_code_i == wtpc_pkg::CODE_LOWER && !master_clear_i)
    |=> lower_bypass_page_limit == $past(accumulator_i[13:0]))
    else $error("lower limit not loaded");
  a_fill_valid: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    ram_we |-> ram_wdata[wtpc_pkg::VALID_POS] && ram_addr == ref_idx)
    else $error("fill without valid bit");
  a_lookup_time: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (state == S_IDLE && req_i) |=> state == S_LOOK)
    else $error("lookup not within one cycle");
  a_fill_flag: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    ram_we |=> u_valid.flag[$past(ref_idx)])
    else $error("filled entry not marked valid");
  a_miss_data: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (state == S_MEM && !ref_wr && mem_rdy_i) |=> cpu_internal_bus_o == $past(mem_rdata_i))
    else $error("miss data not returned");
  a_upper_load: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (write_internal_reg_instr_i && reg_code_i == wtpc_pkg::CODE_UPPER && !master_clear_i)
    |=> upper_bypass_page_limit == $past(accumulator_i[13:0]))
    else $error("upper limit not loaded");
  a_tag_normal: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (ram_we && !extended_mode_i) |-> ram_wdata[30:26] == 5'h00)
    else $error("normal mode tag not masked");
  a_switch_off: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    switch_disable_flag_i |-> !cache_status_word_o[wtpc_pkg::ST_ON])
    else $error("cache on while switched off");
  a_walk_off: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    clearing |-> !cache_status_word_o[wtpc_pkg::ST_ON] && !ram_we)
    else $error("cache active during clear walk");
  a_fills_status: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (state == S_LOOK && arm_fills && ram_we) |=> cache_status_word_o[wtpc_pkg::ST_FILLS])
    else $error("fill after status read not flagged");
endmodule

// >>> sim/wtpc_mem_model.sv
// Purpose: Memory side model answering the cache's memory cycles
// Assumes: One memory cycle at a time; lat_i sets the wait in cycles
// Notes:   Read data toggles when not returned, so stale reads show up
`timescale 1ns/1ps
module wtpc_mem_model (
  // Clock and pacing
  input  wire logic        clk_i,
  input  wire logic [1:0]  lat_i,
  // Memory cycle from the cache
  input  wire logic        req_i,
  input  wire logic        write_i,
  input  wire logic [23:0] addr_i,
  input  wire logic [15:0] wdata_i,
  output      logic        rdy_o,
  output      logic [15:0] rdata_o
);
  logic [15:0] mem [logic [23:0]];
  logic [1:0]  cnt;
  logic        act;
  logic        ret;
  initial begin
    rdy_o = 1'b0;
    rdata_o = 16'h0000;
    act = 1'b0;
    cnt = 2'b00;
  end
  // Read returned only in the ready cycle
  assign ret = act && !rdy_o && cnt == 2'b00 && !write_i;
  // Unwritten words answer a pattern of their address
  always @(posedge clk_i) begin
    if (ret) rdata_o <= mem.exists(addr_i) ? mem[addr_i] : addr_i[15:0] ^ 16'h5a5a;
    else rdata_o <= ~rdata_o;
    if (rdy_o) begin
      rdy_o <= 1'b0;
      act <= 1'b0;
    end else if (req_i && !act) begin
      act <= 1'b1;
      cnt <= lat_i;
    end else if (act && cnt != 2'b00) begin
      cnt <= cnt - 2'b01;
    end else if (act) begin
      rdy_o <= 1'b1;
      if (write_i) mem[addr_i] = wdata_i;
    end
  end
endmodule

// >>> sim/wtpc_top_tb.sv
// Purpose: Self-checking bench for the write-through page cache
// Assumes: Shortened clear window; memory model on the far side
// Notes:   A shadow directory predicts hits, fills and read data
`timescale 1ns/1ps
module wtpc_top_tb;
  localparam int CLR = 40;
  logic        clk = 1'b0;
  logic        rst_n, mc, ext, sw, req, wr, hit, busy, mreq, mwr, mrdy, wreg, rreg;
  logic [9:0]  off;
  logic [13:0] pg, lo, hi;
  logic [15:0] wd, bus, mwd, mrd, acc, st, st_np;
  logic [23:0] maddr;
  logic [3:0]  code;
  logic [1:0]  lat;
  logic [31:0] seed, r;
  int          n_errors, n_compared, i;
  bit          en;
  bit          ev [1024];
  logic [13:0] et [1024];
  logic [15:0] ed [1024];
  logic [15:0] sh [logic [23:0]];
  always #20 clk = ~clk;
  wtpc_top #(.CLEAR_CYCLES(CLR)) uut (.ref_clk_i(clk), .rst_n_i(rst_n),
    .master_clear_i(mc), .extended_mode_i(ext), .switch_disable_flag_i(sw),
    .req_i(req), .write_i(wr), .page_word_offset_i(off), .translated_page_number_i(pg),
    .wdata_i(wd), .hit_o(hit), .cpu_internal_bus_o(bus), .busy_o(busy),
    .mem_req_o(mreq), .mem_write_o(mwr), .mem_addr_o(maddr), .mem_wdata_o(mwd),
    .mem_rdy_i(mrdy), .mem_rdata_i(mrd), .write_internal_reg_instr_i(wreg),
    .read_internal_reg_instr_i(rreg), .reg_code_i(code), .accumulator_i(acc),
    .cache_status_word_o(st));
  // Option absent: only the status word is of interest
  wtpc_top #(.CLEAR_CYCLES(CLR), .PRESENT(1'b0)) uut_np (.ref_clk_i(clk),
    .rst_n_i(rst_n), .master_clear_i(mc), .extended_mode_i(ext),
    .switch_disable_flag_i(sw), .req_i(req), .write_i(wr), .page_word_offset_i(off),
    .translated_page_number_i(pg), .wdata_i(wd), .hit_o(), .cpu_internal_bus_o(),
    .busy_o(), .mem_req_o(), .mem_write_o(), .mem_addr_o(), .mem_wdata_o(),
    .mem_rdy_i(1'b0), .mem_rdata_i(mrd), .write_internal_reg_instr_i(wreg),
    .read_internal_reg_instr_i(rreg), .reg_code_i(code), .accumulator_i(acc),
    .cache_status_word_o(st_np));
  wtpc_mem_model mem (.clk_i(clk), .lat_i(lat), .req_i(mreq), .write_i(mwr),
    .addr_i(maddr), .wdata_i(mwd), .rdy_o(mrdy), .rdata_o(mrd));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Normal mode keeps nine tag bits
  function automatic logic [13:0] tagm(input logic [13:0] p);
    return ext ? p : (p & 14'h01ff);
  endfunction
  function automatic logic [15:0] mword(input logic [23:0] a);
    return sh.exists(a) ? sh[a] : (a[15:0] ^ 16'h5a5a);
  endfunction
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic regw(input logic [3:0] c, input logic [15:0] v);
    @(posedge clk);
    wreg <= 1'b1;
    code <= c;
    acc <= v;
    @(posedge clk);
    wreg <= 1'b0;
  endtask
  // Status read, then one reference, checked against the shadow
  task automatic op(input logic w, input logic [13:0] p, input logic [9:0] o,
                    input logic [15:0] d);
    logic on, hb, fill, mb;
    int   k;
    mb = 1'b0;
    k = 0;
    r = rnd();
    @(posedge clk);
    // Predict after the edge, so mode and switch changes have landed
    on = en && !sw;
    hb = on && !w && ev[o] && et[o] === tagm(p);
    fill = on && !hb && !(p >= lo && p <= hi);
    rreg <= 1'b1;
    code <= wtpc_pkg::CODE_STATUS;
    @(posedge clk);
    rreg <= 1'b0;
    req <= 1'b1;
    wr <= w;
    pg <= p;
    off <= o;
    wd <= d;
    lat <= r[1:0];
    @(posedge clk);
    req <= 1'b0;
    repeat (40) begin
      @(posedge clk);
      #1;
      k++;
      if (mreq) begin
        mb = 1'b1;
        chk("mem_addr", maddr, {p, o});
        chk("mem_write", mwr, w);
        if (w) chk("mem_wdata", mwd, d);
      end
      if (!busy) break;
    end
    chk("busy", busy, 1'b0);
    chk("hit", hit, hb);
    chk("mem_req", mb, !hb);
    if (hb) chk("hit_time", k, 1);
    if (!w) chk("data", bus, hb ? ed[o] : mword({p, o}));
    chk("fills", st[0], fill);
    chk("on", st[1], on);
    chk("switch", st[2], sw);
    if (w) sh[{p, o}] = d;
    if (fill) begin
      ev[o] = 1'b1;
      et[o] = tagm(p);
      ed[o] = w ? d : mword({p, o});
    end
  endtask
  // Clear walk and disable window must both be over
  task automatic settle();
    repeat (1100) @(posedge clk);
    en = 1'b1;
  endtask
  task automatic drop_all();
    en = 1'b0;
    ev = '{default: 1'b0};
  endtask
  initial begin
    #(40 * 60000);
    n_errors++;
    final_report();
  end
  initial begin
    seed = 32'hd364_2f2e;
    {rst_n, mc, sw, req, wr, wreg, rreg, en} = '0;
    ext = 1'b1;
    {off, pg, wd, acc, code, lat} = '0;
    lo = 14'h0000;
    hi = 14'h3fff;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("on_rst", st[1], 1'b0);
    chk("absent", st_np[2], 1'b1);
    op(0, 14'h0001, 10'h011, 16'h0000);
    settle();
    // Whole range inhibited after reset
    op(0, 14'h0001, 10'h011, 16'h0000);
    op(0, 14'h0001, 10'h011, 16'h0000);
    regw(wtpc_pkg::CODE_LOWER, 16'h3000);
    regw(wtpc_pkg::CODE_UPPER, 16'h3fff);
    lo = 14'h3000;
    // Write then hit, conflicting page, both sides of the window's lower limit
    op(1, 14'h0001, 10'h011, 16'hbeef);
    op(0, 14'h0001, 10'h011, 16'h0000);
    op(0, 14'h0002, 10'h011, 16'h0000);
    op(0, 14'h0001, 10'h011, 16'h0000);
    op(0, 14'h3000, 10'h005, 16'h0000);
    op(0, 14'h3000, 10'h005, 16'h0000);
    op(0, 14'h2fff, 10'h005, 16'h0000);
    op(0, 14'h2fff, 10'h005, 16'h0000);
    for (i = 0; i < 200; i++) begin
      r = rnd();
      op(r[13], r[4] ? (14'h3000 | r[1:0]) : {11'h000, r[7:5]},
         r[8] ? 10'h3ff : {6'h00, r[12:9]}, r[31:16]);
    end
    // Manual disable: reads miss and nothing fills
    @(posedge clk);
    sw <= 1'b1;
    op(0, 14'h0001, 10'h011, 16'h0000);
    op(0, 14'h0002, 10'h3ff, 16'h0000);
    @(posedge clk);
    sw <= 1'b0;
    // Widened window, then a clear
    regw(wtpc_pkg::CODE_LOWER, 16'h2000);
    lo = 14'h2000;
    regw(wtpc_pkg::CODE_CLEAR, 16'h0000);
    drop_all();
    repeat (2) @(posedge clk);
    #1;
    chk("on_clear", st[1], 1'b0);
    op(0, 14'h0001, 10'h011, 16'h0000);
    settle();
    op(0, 14'h0001, 10'h011, 16'h0000);
    op(0, 14'h0001, 10'h011, 16'h0000);
    // Normal mode compares nine tag bits only
    @(posedge clk);
    ext <= 1'b0;
    op(1, 14'h0005, 10'h155, 16'h1234);
    op(0, 14'h0205, 10'h155, 16'h0000);
    @(posedge clk);
    ext <= 1'b1;
    // Master clear restores the full inhibit
    @(posedge clk);
    mc <= 1'b1;
    @(posedge clk);
    mc <= 1'b0;
    drop_all();
    lo = 14'h0000;
    hi = 14'h3fff;
    settle();
    op(0, 14'h0002, 10'h011, 16'h0000);
    op(0, 14'h0002, 10'h011, 16'h0000);
    final_report();
  end
endmodule
